// file: hw/epav_regs.sv
// Negotiation advertisement, partner ability, expansion and vendor configuration registers.
`timescale 1ns/1ps
// Function
// - Advertisement bit 5 is read/write, resets to 1, and advertises 10 Mb half duplex.
// - Advertisement bits 4:0 read as the fixed selector 0x01 out of 32 codes.
// - The partner ability register at 0x05 is read-only, resets to 0 and captures the partner page.
// - The partner selector decodes to Ethernet, ISLAN, token ring, serial bus or reserved.
// - The expansion register at 0x06 is read-only, resets to 0 and reports both ends' capabilities.
// - The vendor register at 0x10 resets to 0x0140 with bits 9:6 fixed at 0x5 and bit 13 zero.
// - Vendor bit 5 disables auto polarity; when clear, reversed 10 Mb receive data is inverted.
// - Vendor bit 1 bypasses the coding sublayer only with negotiation off and 100 Mb selected.
// - Vendor bit 0 stops the idle 100 Mb receive clock unless loopback is set.
module epav_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_ff,
  input wire logic lp_page_valid,
  input wire logic [15:0] lp_page,
  input wire logic an_complete,
  input wire logic partner_an_able,
  input wire logic page_received,
  input wire logic local_np_able,
  input wire logic partner_np_able,
  input wire logic an_enable,
  input wire logic speed_100,
  input wire logic loopback_bit,
  input wire logic rx_active,
  input wire logic rx_polarity_reversed,
  input wire logic rx_data,
  input wire logic irq_request,
  output logic ten_half_duplex_ability_ff,
  output epav_pkg::epav_sel_kind_t lp_sel_kind_ff,
  output logic [15:0] vendor_cfg_ff,
  output logic rx_data_ff,
  output logic phy_irq_ff,
  output logic pcs_bypass_ff,
  output logic rx_clk_stop_ff
);
  logic [15:0] lpa_ff;
  logic [15:0] exp_ff;
  logic [15:0] nxt_rdata;
  logic rx_invert;

  // ----------------------------------------
  // Advertisement register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ten_half_duplex_ability_ff <= epav_pkg::ADV_TEN_HALF_RST;
    end else if (reg_wr && reg_addr == epav_pkg::ADV_OFF) begin
      ten_half_duplex_ability_ff <= reg_wdata[epav_pkg::ADV_TEN_HALF_BIT];
    end
  end

  // ----------------------------------------
  // Partner ability capture
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lpa_ff <= epav_pkg::LPA_RST;
    end else if (lp_page_valid) begin
      lpa_ff <= lp_page;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_sel_kind_ff <= epav_pkg::SELK_RESERVED;
    end else begin
      unique case (lpa_ff[4:0])
        epav_pkg::SEL_ETHERNET: begin
          lp_sel_kind_ff <= epav_pkg::SELK_ETHERNET;
        end
        epav_pkg::SEL_ISLAN: begin
          lp_sel_kind_ff <= epav_pkg::SELK_ISLAN;
        end
        epav_pkg::SEL_TOKEN_RING: begin
          lp_sel_kind_ff <= epav_pkg::SELK_TOKEN_RING;
        end
        epav_pkg::SEL_SERIAL_BUS: begin
          lp_sel_kind_ff <= epav_pkg::SELK_SERIAL_BUS;
        end
        default: begin
          lp_sel_kind_ff <= epav_pkg::SELK_RESERVED;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Expansion capture
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_ff <= epav_pkg::EXP_RST;
    end else if (an_complete) begin
      exp_ff <= epav_pkg::EXP_RST;
      exp_ff[epav_pkg::EXP_PARTNER_AN_BIT] <= partner_an_able;
      exp_ff[epav_pkg::EXP_PAGE_RX_BIT] <= page_received;
      exp_ff[epav_pkg::EXP_LOCAL_NP_BIT] <= local_np_able;
      exp_ff[epav_pkg::EXP_PARTNER_NP_BIT] <= partner_np_able;
    end
  end

  // ----------------------------------------
  // Vendor configuration register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vendor_cfg_ff <= epav_pkg::VND_RST;
    end else if (reg_wr && reg_addr == epav_pkg::VND_OFF) begin
      vendor_cfg_ff <= (reg_wdata & epav_pkg::VND_WR_MASK) | epav_pkg::VND_FIXED;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_comb begin
    nxt_rdata = 16'h0000;
    unique case (reg_addr)
      epav_pkg::ADV_OFF: begin
        nxt_rdata[epav_pkg::ADV_TEN_HALF_BIT] = ten_half_duplex_ability_ff;
        nxt_rdata[4:0] = epav_pkg::ADV_SELECTOR;
      end
      epav_pkg::LPA_OFF: begin
        nxt_rdata = lpa_ff;
      end
      epav_pkg::EXP_OFF: begin
        nxt_rdata = exp_ff;
      end
      epav_pkg::VND_OFF: begin
        nxt_rdata = vendor_cfg_ff;
        if (!vendor_cfg_ff[epav_pkg::VND_AUTO_POLARITY_DISABLE_BIT]) begin
          nxt_rdata[epav_pkg::VND_RX_INVERSION_BIT_BIT] = rx_polarity_reversed;
        end
      end
      default: begin
        nxt_rdata = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // Vendor controls
  // ----------------------------------------
  assign rx_invert = vendor_cfg_ff[epav_pkg::VND_AUTO_POLARITY_DISABLE_BIT] ? vendor_cfg_ff[epav_pkg::VND_RX_INVERSION_BIT_BIT]
                                                           : rx_polarity_reversed;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_ff <= 1'b0;
      phy_irq_ff <= 1'b1;
      pcs_bypass_ff <= 1'b0;
      rx_clk_stop_ff <= 1'b0;
    end else begin
      rx_data_ff <= rx_data ^ rx_invert;
      phy_irq_ff <= vendor_cfg_ff[epav_pkg::VND_IRQ_POL_BIT] ? irq_request : ~irq_request;
      pcs_bypass_ff <= vendor_cfg_ff[epav_pkg::VND_CODING_SUBLAYER_BYPASS_BIT] & ~an_enable & speed_100;
      rx_clk_stop_ff <= vendor_cfg_ff[epav_pkg::VND_RX_CLOCK_GATING_BIT_BIT] & ~loopback_bit & speed_100 & ~rx_active;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_adv_write_ability: assert property (
    reg_wr && reg_addr == epav_pkg::ADV_OFF |=> ten_half_duplex_ability_ff == $past(reg_wdata[5]))
    else $error("Advertisement ability bit did not take the write.");
  a_adv_selector_fixed: assert property (
    reg_rd && reg_addr == epav_pkg::ADV_OFF |=> reg_rdata_ff[4:0] == 5'h01)
    else $error("Advertisement selector is not 0x01.");
  a_lpa_capture_hold: assert property (
    lp_page_valid ##1 !lp_page_valid [*2] |-> lpa_ff == $past(lp_page, 2))
    else $error("Partner page not captured or not held.");
  a_sel_ethernet_decode: assert property (
    lpa_ff[4:0] == 5'h01 |=> lp_sel_kind_ff == epav_pkg::SELK_ETHERNET)
    else $error("Ethernet selector decoded wrongly.");
  a_sel_reserved_decode: assert property (
    lpa_ff[4:0] == 5'h00 || lpa_ff[4:0] > 5'h04 |=> lp_sel_kind_ff == epav_pkg::SELK_RESERVED)
    else $error("Reserved selector decoded wrongly.");
  a_exp_report_caps: assert property (
    an_complete |=> exp_ff[3:0] == {$past(partner_np_able), $past(local_np_able), $past(page_received),
                                    $past(partner_an_able)} && exp_ff[15:4] == 12'h000)
    else $error("Expansion bits do not follow negotiation result.");
  a_vnd_fixed_bits: assert property (
    vendor_cfg_ff[9:6] == 4'h5 && !vendor_cfg_ff[13] && vendor_cfg_ff[3:2] == 2'h0)
    else $error("Vendor fixed bits changed.");
  a_irq_polarity_map: assert property (
    ##1 phy_irq_ff == ($past(vendor_cfg_ff[14]) ? $past(irq_request) : !$past(irq_request)))
    else $error("Interrupt polarity mapping wrong.");
  a_auto_pol_invert: assert property (
    !vendor_cfg_ff[5] && rx_polarity_reversed |=> rx_data_ff == !$past(rx_data))
    else $error("Reversed receive data not inverted.");
  a_pcs_bypass_gate: assert property (
    an_enable || !speed_100 |=> !pcs_bypass_ff)
    else $error("Coding bypass active outside forced 100 Mb.");
  a_rx_clk_loopback: assert property (
    loopback_bit |=> !rx_clk_stop_ff)
    else $error("Receive clock stopped during loopback.");

  c_partner_page: cover property (lp_page_valid ##1 lp_sel_kind_ff != epav_pkg::SELK_RESERVED);
  c_clear_ten_half: cover property (reg_wr && reg_addr == epav_pkg::ADV_OFF && !reg_wdata[5]);
  c_rx_clk_stop: cover property (rx_clk_stop_ff);
  c_irq_high: cover property (vendor_cfg_ff[14] && phy_irq_ff);
endmodule : epav_regs

// file: hw/epav_pkg.sv
// Package of offsets, field positions and reset values for the PHY negotiation and vendor registers.
package epav_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [4:0] ADV_OFF = 5'h04;
  localparam logic [4:0] LPA_OFF = 5'h05;
  localparam logic [4:0] EXP_OFF = 5'h06;
  localparam logic [4:0] VND_OFF = 5'h10;
  // ----------------------------------------
  // Advertisement fields
  // ----------------------------------------
  localparam int ADV_TEN_HALF_BIT = 5;
  localparam logic ADV_TEN_HALF_RST = 1'b1;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  // ----------------------------------------
  // Partner selector codes
  // ----------------------------------------
  localparam logic [4:0] SEL_ETHERNET = 5'h01;
  localparam logic [4:0] SEL_ISLAN = 5'h02;
  localparam logic [4:0] SEL_TOKEN_RING = 5'h03;
  localparam logic [4:0] SEL_SERIAL_BUS = 5'h04;
  localparam logic [15:0] LPA_RST = 16'h0000;
  localparam logic [15:0] EXP_RST = 16'h0000;
  // ----------------------------------------
  // Expansion fields
  // ----------------------------------------
  localparam int EXP_PARTNER_AN_BIT = 0;
  localparam int EXP_PAGE_RX_BIT = 1;
  localparam int EXP_LOCAL_NP_BIT = 2;
  localparam int EXP_PARTNER_NP_BIT = 3;
  // ----------------------------------------
  // Vendor configuration fields
  // ----------------------------------------
  localparam logic [15:0] VND_RST = 16'h0140;
  localparam logic [15:0] VND_WR_MASK = 16'hDC33;
  localparam logic [15:0] VND_FIXED = 16'h0140;
  localparam int VND_IRQ_POL_BIT = 14;
  localparam int VND_AUTO_POLARITY_DISABLE_BIT = 5;
  localparam int VND_RX_INVERSION_BIT_BIT = 4;
  localparam int VND_CODING_SUBLAYER_BYPASS_BIT = 1;
  localparam int VND_RX_CLOCK_GATING_BIT_BIT = 0;
  typedef enum logic [4:0] {
    SELK_RESERVED = 5'h01,
    SELK_ETHERNET = 5'h02,
    SELK_ISLAN = 5'h04,
    SELK_TOKEN_RING = 5'h08,
    SELK_SERIAL_BUS = 5'h10
  } epav_sel_kind_t;
endpackage : epav_pkg

// file: tb/epav_link_partner.sv
// Behavioural link partner that sends one base page and then completes negotiation.
`timescale 1ns/1ps
module epav_link_partner (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [15:0] page,
  output logic lp_page_valid = 1'b0,
  output logic [15:0] lp_page = 16'hA5A5,
  output logic an_complete = 1'b0,
  output logic partner_an_able = 1'b0,
  output logic page_received = 1'b0,
  output logic partner_np_able = 1'b0
);
  // The page stands for one cycle, then the lines carry its inverse.
  always @(posedge core_clk) begin
    if (rst_n && go) begin
      #1 lp_page = page;
      lp_page_valid = 1'b1;
      @(posedge core_clk) #1 lp_page_valid = 1'b0;
      lp_page = ~page;
      an_complete = 1'b1;
      partner_an_able = 1'b1;
      page_received = 1'b1;
      partner_np_able = page[15];
      @(posedge core_clk) #1 an_complete = 1'b0;
    end
  end
endmodule : epav_link_partner

// file: tb/tb.sv
// Self-checking bench for the negotiation and vendor register block.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, page = 16'h0000;
  logic local_np_able = 1'b0, an_enable = 1'b1, speed_100 = 1'b0, loopback_bit = 1'b0, rx_active = 1'b0;
  logic rx_polarity_reversed = 1'b0, rx_data = 1'b0, irq_request = 1'b0;
  logic lp_page_valid, an_complete, partner_an_able, page_received, partner_np_able;
  logic [15:0] lp_page, reg_rdata_ff, vendor_cfg_ff;
  logic ten_half_duplex_ability_ff, rx_data_ff, phy_irq_ff, pcs_bypass_ff, rx_clk_stop_ff;
  epav_pkg::epav_sel_kind_t lp_sel_kind_ff;
  int fail_count = 0;
  int checks_done = 0;
  always #5 core_clk = ~core_clk;
  epav_link_partner u_partner (.core_clk(core_clk), .rst_n(rst_n), .go(go), .page(page),
    .lp_page_valid(lp_page_valid), .lp_page(lp_page), .an_complete(an_complete),
    .partner_an_able(partner_an_able), .page_received(page_received), .partner_np_able(partner_np_able));
  epav_regs DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .lp_page_valid(lp_page_valid), .lp_page(lp_page),
    .an_complete(an_complete), .partner_an_able(partner_an_able), .page_received(page_received),
    .local_np_able(local_np_able), .partner_np_able(partner_np_able), .an_enable(an_enable),
    .speed_100(speed_100), .loopback_bit(loopback_bit), .rx_active(rx_active),
    .rx_polarity_reversed(rx_polarity_reversed), .rx_data(rx_data), .irq_request(irq_request),
    .ten_half_duplex_ability_ff(ten_half_duplex_ability_ff), .lp_sel_kind_ff(lp_sel_kind_ff),
    .vendor_cfg_ff(vendor_cfg_ff), .rx_data_ff(rx_data_ff), .phy_irq_ff(phy_irq_ff),
    .pcs_bypass_ff(pcs_bypass_ff), .rx_clk_stop_ff(rx_clk_stop_ff));
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({15'h0000, got}, {15'h0000, exp});
  endtask : cmp_bit
  task automatic step;
    @(posedge core_clk) #1;
  endtask : step
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk) #1 reg_wr = 1'b0;
    step;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk) #1 reg_rd = 1'b0;
    cmp_word(reg_rdata_ff, exp);
    step;
  endtask : rd
  task automatic t_reset;
    cmp_bit(ten_half_duplex_ability_ff, 1'b1);
    cmp_bit(phy_irq_ff, 1'b1);
    cmp_word(vendor_cfg_ff, 16'h0140);
    cmp_word({11'h000, lp_sel_kind_ff}, 16'h0001);
    rd(5'h04, 16'h0021);
    rd(5'h05, 16'h0000);
    rd(5'h06, 16'h0000);
    rd(5'h10, 16'h0140);
    $display("reset test done");
  endtask : t_reset
  task automatic t_adv;
    wr(5'h04, 16'hFFDF);
    rd(5'h04, 16'h0001);
    cmp_bit(ten_half_duplex_ability_ff, 1'b0);
    wr(5'h04, 16'hFFFF);
    rd(5'h04, 16'h0021);
    $display("advertisement test done");
  endtask : t_adv
  task automatic t_vendor;
    wr(5'h10, 16'hFFFF);
    rd(5'h10, 16'hDD73);
    cmp_word(vendor_cfg_ff, 16'hDD73);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    wr(5'h06, 16'hFFFF);
    rd(5'h06, 16'h0000);
    rd(5'h1F, 16'h0000);
    wr(5'h10, 16'h0000);
    rd(5'h10, 16'h0140);
    cmp_word(vendor_cfg_ff, 16'h0140);
    $display("vendor register test done");
  endtask : t_vendor
  task automatic t_partner;
    epav_pkg::epav_sel_kind_t k;
    for (int i = 0; i < 7; i++) begin
      page = {i[0], 10'h155, (i == 6) ? 5'h1F : 5'(i)};
      local_np_able = i[1];
      go = 1'b1;
      @(posedge core_clk) #1 go = 1'b0;
      repeat (2) step;
      case (page[4:0])
        5'h01: k = epav_pkg::SELK_ETHERNET;
        5'h02: k = epav_pkg::SELK_ISLAN;
        5'h03: k = epav_pkg::SELK_TOKEN_RING;
        5'h04: k = epav_pkg::SELK_SERIAL_BUS;
        default: k = epav_pkg::SELK_RESERVED;
      endcase
      cmp_word({11'h000, lp_sel_kind_ff}, {11'h000, k});
      rd(5'h05, page);
      rd(5'h06, {12'h000, page[15], i[1], 2'b11});
    end
    $display("partner test done");
  endtask : t_partner
  task automatic t_ctrl;
    wr(5'h10, 16'h4000);
    irq_request = 1'b1;
    step;
    cmp_bit(phy_irq_ff, 1'b1);
    wr(5'h10, 16'h0000);
    step;
    cmp_bit(phy_irq_ff, 1'b0);
    irq_request = 1'b0;
    rx_polarity_reversed = 1'b1;
    rx_data = 1'b1;
    step;
    cmp_bit(phy_irq_ff, 1'b1);
    cmp_bit(rx_data_ff, 1'b0);
    rd(5'h10, 16'h0150);
    wr(5'h10, 16'h0023);
    an_enable = 1'b0;
    speed_100 = 1'b1;
    step;
    cmp_bit(rx_data_ff, 1'b1);
    cmp_bit(pcs_bypass_ff, 1'b1);
    cmp_bit(rx_clk_stop_ff, 1'b1);
    an_enable = 1'b1;
    loopback_bit = 1'b1;
    step;
    cmp_bit(pcs_bypass_ff, 1'b0);
    cmp_bit(rx_clk_stop_ff, 1'b0);
    rx_polarity_reversed = 1'b0;
    wr(5'h10, 16'h0030);
    step;
    cmp_bit(rx_data_ff, 1'b0);
    rd(5'h10, 16'h0170);
    $display("control test done");
  endtask : t_ctrl
  task automatic tally_and_finish;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    t_reset;
    t_adv;
    t_vendor;
    t_partner;
    t_ctrl;
    tally_and_finish;
  end
endmodule : tb
